// [verilog/dipf_deframer.sv]
`timescale 1ns/1ns
`include "dipf_defs.svh"

module dipf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW-1:0] wr_next = (wr_reg == LAST_PTR) ? '0 : wr_reg + 1'b1;
    wire [AW-1:0] rd_next = (rd_reg == LAST_PTR) ? '0 : rd_reg + 1'b1;

    assign in_ready = (cnt_reg != FULL_CNT);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_next;
            end
            if (pop) begin
                rd_reg <= rd_next;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

// How it works
// R01: Source chooses island start and length
// R02: Control periods at least twelve characters
// R03: Island holds a packet, 36 characters minimum
// R04: Whole packets only, at most eighteen
// R05: Any number of islands between video
// R06: Source sends an island every two fields
// R07: Two guard characters open and close islands
// R08: Guard channel 0 nibble 0xC-0xF from syncs
// R09: Guard channels 1, 2 carry fixed character
// R10: Each packet spans thirty-two characters
// R11: Subpacket is 56 data, 8 parity bits
// R12: Block N rides bit N, channels 1, 2
// R13: Subpacket k bytes are body bytes 7k..7k+6
// R14: Parity generator is 1+x^6+x^7+x^8
// R15: Header parity covers 24 header bits only
// R16: First header byte is packet type
// R17: Base packet type codes decoded to classes
// R18: Info frames are 0x80 plus frame type
// R19: Every packet type accepted without harm
// R20: Null packets are all zero bytes
// R21: Null packet header tail and body ignored
// R22: Eight 1010 control characters announce islands
// R23: Channel 0 carries syncs and header bit
// R24: Bits go LSB first, even on channel 1
module dipf_deframer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link side
    input wire logic link_clk,
    input wire dipf_pkg::dipf_link_t link_in,
    // Packet output
    output logic pkt_valid,
    input wire logic pkt_ready,
    output dipf_pkg::dipf_packet_t pkt_out,
    // Status
    output logic island_active,
    output logic [1:0] island_sync,
    output logic guard_err,
    output logic too_many_pkts,
    output logic short_ctl,
    output logic overflow
);
    localparam int PKT_W = $bits(dipf_pkg::dipf_packet_t);

    function automatic logic [7:0] dipf_bch(input logic [55:0] d,
                                            input int n);
        logic [7:0] e;
        logic fb;
        e = 8'h00;
        for (int i = 0; i < 56; i++) begin
            if (i < n) begin
                fb = d[i] ^ e[0];
                e = {1'b0, e[7:1]} ^ (fb ? `DIPF_BCH_POLY : 8'h00);
            end
        end
        return e;
    endfunction

    function automatic dipf_pkg::dipf_class_t dipf_class_of(
        input logic [7:0] t);
        dipf_pkg::dipf_class_t c;
        c = dipf_pkg::DIPF_CLS_UNKNOWN;
        case (t)
            `DIPF_TYPE_NULL: c = dipf_pkg::DIPF_CLS_NULL;
            `DIPF_TYPE_CLK_REGEN: c = dipf_pkg::DIPF_CLS_CLK_REGEN;
            `DIPF_TYPE_AUDIO: c = dipf_pkg::DIPF_CLS_AUDIO;
            `DIPF_TYPE_GEN_CTRL: c = dipf_pkg::DIPF_CLS_GEN_CTRL;
            `DIPF_TYPE_CONTENT_PROT: c = dipf_pkg::DIPF_CLS_CONTENT_PROT;
            `DIPF_TYPE_REC_CODE_A: c = dipf_pkg::DIPF_CLS_REC_CODE_A;
            `DIPF_TYPE_REC_CODE_B: c = dipf_pkg::DIPF_CLS_REC_CODE_B;
            `DIPF_TYPE_ONE_BIT_AUDIO: c = dipf_pkg::DIPF_CLS_ONE_BIT_AUDIO;
            `DIPF_TYPE_DIRECT_STREAM: c = dipf_pkg::DIPF_CLS_DIRECT_STREAM;
            `DIPF_TYPE_HIGH_BITRATE: c = dipf_pkg::DIPF_CLS_HIGH_BITRATE;
            `DIPF_TYPE_GAMUT: c = dipf_pkg::DIPF_CLS_GAMUT;
            default: begin
                if (t > `DIPF_TYPE_INFO_BASE && t <= `DIPF_TYPE_INFO_LAST) begin
                    c = dipf_pkg::DIPF_CLS_INFO_FRAME;
                end
            end
        endcase
        return c;
    endfunction

    // Synchronisers
    logic clk_s1_reg;
    logic clk_s2_reg;
    logic clk_s3_reg;
    dipf_pkg::dipf_link_t lnk_s1_reg;
    dipf_pkg::dipf_link_t lnk_s2_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            lnk_s1_reg <= '0;
            lnk_s2_reg <= '0;
        end else begin
            clk_s1_reg <= link_clk;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            lnk_s1_reg <= link_in;
            lnk_s2_reg <= lnk_s1_reg;
        end
    end

    // Character strobe on the falling link edge, mid-character
    wire chr_stb = clk_s3_reg && !clk_s2_reg;
    dipf_pkg::dipf_link_t w;
    assign w = lnk_s2_reg;
    wire is_pre = w.ctl && (w.control_code_bits == `DIPF_ISLAND_CTL);
    wire is_guard = !w.ctl && (w.char1 == `DIPF_GUARD_CHAR) // see R09
        && (w.char2 == `DIPF_GUARD_CHAR)
        && (w.nib0[3:2] == `DIPF_GUARD_NIB_TOP); // see R08

    dipf_pkg::dipf_state_t state_reg;
    dipf_pkg::dipf_state_t state_next;
    logic [3:0] pre_cnt_reg;
    logic [4:0] bit_cnt_reg;
    logic [4:0] pkt_cnt_reg;
    logic [3:0] ctl_cnt_reg;
    logic prev_ctl_reg;
    logic done_reg;
    logic [31:0] hdr_reg;
    logic [63:0] sub_reg [0:3];

    wire in_pkt = (state_reg == dipf_pkg::DIPF_ST_PACKET);
    wire in_next = (state_reg == dipf_pkg::DIPF_ST_NEXT);
    wire capture = chr_stb && !w.ctl && (in_pkt || (in_next && !is_guard));
    wire [4:0] idx = in_next ? 5'h00 : bit_cnt_reg;
    wire last_chr = capture && (idx == `DIPF_PKT_LAST); // see R10
    wire pre_full = is_pre && (pre_cnt_reg == `DIPF_PREAMBLE_LEN - 4'h1);
    wire sync_upd = chr_stb && !w.ctl && (state_reg != dipf_pkg::DIPF_ST_HUNT)
        && (state_reg != dipf_pkg::DIPF_ST_ARMED || is_guard);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dipf_pkg::DIPF_ST_HUNT: begin
                if (pre_full) begin
                    state_next = dipf_pkg::DIPF_ST_ARMED; // see R22
                end
            end
            dipf_pkg::DIPF_ST_ARMED: begin
                if (is_guard) begin
                    state_next = dipf_pkg::DIPF_ST_LEAD; // see R07
                end else if (!is_pre) begin
                    state_next = dipf_pkg::DIPF_ST_HUNT;
                end
            end
            dipf_pkg::DIPF_ST_LEAD: begin
                state_next = is_guard ? dipf_pkg::DIPF_ST_PACKET
                                      : dipf_pkg::DIPF_ST_HUNT; // see R07
            end
            dipf_pkg::DIPF_ST_PACKET: begin
                if (w.ctl) begin
                    state_next = dipf_pkg::DIPF_ST_HUNT;
                end else if (last_chr) begin
                    state_next = dipf_pkg::DIPF_ST_NEXT;
                end
            end
            dipf_pkg::DIPF_ST_NEXT: begin
                if (is_guard) begin
                    state_next = dipf_pkg::DIPF_ST_TRAIL; // see R07
                end else if (w.ctl) begin
                    state_next = dipf_pkg::DIPF_ST_HUNT;
                end else begin
                    state_next = dipf_pkg::DIPF_ST_PACKET; // see R04
                end
            end
            dipf_pkg::DIPF_ST_TRAIL: begin
                state_next = dipf_pkg::DIPF_ST_HUNT; // see R05
            end
            default: begin
                state_next = dipf_pkg::DIPF_ST_HUNT;
            end
        endcase
    end

    wire lead_bad = (state_reg == dipf_pkg::DIPF_ST_LEAD) && !is_guard;
    wire trail_bad = (state_reg == dipf_pkg::DIPF_ST_TRAIL) && !is_guard;
    wire pkt_abort = (in_pkt || in_next) && w.ctl;
    wire ctl_end = prev_ctl_reg && !w.ctl;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= dipf_pkg::DIPF_ST_HUNT;
        end else if (chr_stb) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_reg <= 4'h0;
            ctl_cnt_reg <= 4'h0;
            prev_ctl_reg <= 1'b0;
        end else if (chr_stb) begin
            pre_cnt_reg <= is_pre && !pre_full ? pre_cnt_reg + 4'h1 : 4'h0;
            prev_ctl_reg <= w.ctl;
            if (!w.ctl) begin
                ctl_cnt_reg <= 4'h0;
            end else if (ctl_cnt_reg != 4'hF) begin
                ctl_cnt_reg <= ctl_cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 5'h00;
            pkt_cnt_reg <= 5'h00;
        end else if (chr_stb) begin
            if (state_reg == dipf_pkg::DIPF_ST_LEAD) begin
                bit_cnt_reg <= 5'h00;
                pkt_cnt_reg <= 5'h00;
            end else if (capture) begin
                bit_cnt_reg <= idx + 5'h01; // see R10
                if (last_chr && pkt_cnt_reg != 5'h1F) begin
                    pkt_cnt_reg <= pkt_cnt_reg + 5'h01;
                end
            end
        end
    end

    // Header bit on channel 0 bit 2, LSB first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hdr_reg <= 32'h0000_0000;
        end else if (capture) begin
            hdr_reg[idx] <= w.nib0[2]; // see R23
        end
    end

    // Block n on bit n: even bit channel 1, odd bit channel 2
    for (genvar n = 0; n < 4; n++) begin : g_sub
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                sub_reg[n] <= 64'h0;
            end else if (capture) begin
                sub_reg[n][{idx, 1'b0}] <= w.nib1[n]; // see R12
                sub_reg[n][{idx, 1'b1}] <= w.nib2[n]; // see R24
            end
        end
    end

    // Packet assembly
    dipf_pkg::dipf_packet_t pkt_asm;
    wire [7:0] hb0 = hdr_reg[7:0]; // see R16
    wire is_null = (hb0 == `DIPF_TYPE_NULL);
    wire [7:0] hdr_par = dipf_bch({32'h0, hdr_reg[23:0]},
                                  `DIPF_HDR_DATA_BITS); // see R15
    logic [223:0] body;
    logic [3:0] sub_bad;

    for (genvar k = 0; k < 4; k++) begin : g_body
        // Subpacket k byte j lands at body byte 7k+j
        assign body[k*56 +: 56] = sub_reg[k][55:0]; // see R13
        assign sub_bad[k] = dipf_bch(sub_reg[k][55:0],
            `DIPF_SUB_DATA_BITS) != sub_reg[k][63:56]; // see R11 see R14
    end

    assign pkt_asm.pkt_class = dipf_class_of(hb0); // see R17 see R18
    assign pkt_asm.header_byte_zero = hb0;
    assign pkt_asm.header_byte_one = is_null ? 8'h00 : hdr_reg[15:8]; // see R21
    assign pkt_asm.header_byte_two = is_null ? 8'h00 : hdr_reg[23:16];
    assign pkt_asm.packet_body_bytes = is_null ? 224'h0 : body; // see R21
    assign pkt_asm.hdr_err = (hdr_par != hdr_reg[31:24]); // see R14
    assign pkt_asm.sub_err = sub_bad;
    assign pkt_asm.sync = island_sync;

    logic fifo_ready;

    // Every type is queued, unknown ones included; null packets get their header tail and body zeroed
    dipf_fifo #(
        .WIDTH(PKT_W),
        .DEPTH(`DIPF_FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(done_reg), // see R19
        .in_ready(fifo_ready),
        .in_data(pkt_asm),
        .out_valid(pkt_valid),
        .out_ready(pkt_ready),
        .out_data(pkt_out)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            island_sync <= 2'h0;
            guard_err <= 1'b0;
            too_many_pkts <= 1'b0;
            short_ctl <= 1'b0;
            overflow <= 1'b0;
            island_active <= 1'b0;
        end else begin
            done_reg <= last_chr;
            overflow <= done_reg && !fifo_ready;
            guard_err <= chr_stb && (lead_bad || trail_bad || pkt_abort);
            too_many_pkts <= last_chr
                && (pkt_cnt_reg >= `DIPF_MAX_PKTS); // see R04
            short_ctl <= chr_stb && ctl_end
                && (ctl_cnt_reg < `DIPF_CTL_MIN_CHARS); // see R02
            island_active <= (state_reg != dipf_pkg::DIPF_ST_HUNT)
                && (state_reg != dipf_pkg::DIPF_ST_ARMED);
            if (sync_upd) begin
                island_sync <= w.nib0[1:0]; // see R23 see R08
            end
        end
    end
endmodule

// [verilog/dipf_defs.svh]
`ifndef DIPF_DEFS_SVH
`define DIPF_DEFS_SVH

// Link timing
`define DIPF_REF_PERIOD_NS 4
`define DIPF_LINK_PERIOD_NS 32
`define DIPF_CTL_MIN_CHARS 4'hC
`define DIPF_PREAMBLE_LEN 4'h8

// Character codes
`define DIPF_ISLAND_CTL 4'h5
`define DIPF_GUARD_CHAR 10'h133
`define DIPF_GUARD_NIB_TOP 2'h3

// Packet structure
`define DIPF_PKT_LAST 5'h1F
`define DIPF_MAX_PKTS 5'h12
`define DIPF_HDR_DATA_BITS 24
`define DIPF_SUB_DATA_BITS 56
`define DIPF_BCH_POLY 8'h83
`define DIPF_FIFO_DEPTH 8

// Packet type codes
`define DIPF_TYPE_NULL 8'h00
`define DIPF_TYPE_CLK_REGEN 8'h01
`define DIPF_TYPE_AUDIO 8'h02
`define DIPF_TYPE_GEN_CTRL 8'h03
`define DIPF_TYPE_CONTENT_PROT 8'h04
`define DIPF_TYPE_REC_CODE_A 8'h05
`define DIPF_TYPE_REC_CODE_B 8'h06
`define DIPF_TYPE_ONE_BIT_AUDIO 8'h07
`define DIPF_TYPE_DIRECT_STREAM 8'h08
`define DIPF_TYPE_HIGH_BITRATE 8'h09
`define DIPF_TYPE_GAMUT 8'h0A
`define DIPF_TYPE_INFO_BASE 8'h80
`define DIPF_TYPE_INFO_LAST 8'h85

`endif

// [verilog/dipf_pkg.sv]
package dipf_pkg;

    typedef enum logic [3:0] {
        DIPF_CLS_NULL,
        DIPF_CLS_CLK_REGEN,
        DIPF_CLS_AUDIO,
        DIPF_CLS_GEN_CTRL,
        DIPF_CLS_CONTENT_PROT,
        DIPF_CLS_REC_CODE_A,
        DIPF_CLS_REC_CODE_B,
        DIPF_CLS_ONE_BIT_AUDIO,
        DIPF_CLS_DIRECT_STREAM,
        DIPF_CLS_HIGH_BITRATE,
        DIPF_CLS_GAMUT,
        DIPF_CLS_INFO_FRAME,
        DIPF_CLS_UNKNOWN
    } dipf_class_t;

    typedef enum {
        DIPF_ST_HUNT,
        DIPF_ST_ARMED,
        DIPF_ST_LEAD,
        DIPF_ST_PACKET,
        DIPF_ST_NEXT,
        DIPF_ST_TRAIL
    } dipf_state_t;

    typedef struct packed {
        logic ctl;
        logic [3:0] control_code_bits;
        logic [3:0] nib0;
        logic [3:0] nib1;
        logic [3:0] nib2;
        logic [9:0] char1;
        logic [9:0] char2;
    } dipf_link_t;

    typedef struct packed {
        dipf_class_t pkt_class;
        logic [7:0] header_byte_zero;
        logic [7:0] header_byte_one;
        logic [7:0] header_byte_two;
        logic [223:0] packet_body_bytes;
        logic hdr_err;
        logic [3:0] sub_err;
        logic [1:0] sync;
    } dipf_packet_t;

endpackage

// [verilog/dipf_fix_note_unused.sv]
`timescale 1ns/1ns

// [verif/dipf_deframer_assertions.sv]
`timescale 1ns/1ns
module dipf_deframer_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link side
    input wire logic link_clk,
    input wire dipf_pkg::dipf_link_t link_in,
    // Packet output
    input wire logic pkt_valid,
    input wire logic pkt_ready,
    input wire dipf_pkg::dipf_packet_t pkt_out,
    // Status
    input wire logic island_active,
    input wire logic [1:0] island_sync,
    input wire logic guard_err,
    input wire logic too_many_pkts,
    input wire logic short_ctl,
    input wire logic overflow
);
    logic [7:0] hb0;
    assign hb0 = pkt_out.header_byte_zero;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_hold;
        pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled packet changed");
    property p_base;
        pkt_valid && hb0 <= 8'h0A |->
            pkt_out.pkt_class == dipf_pkg::dipf_class_t'(hb0[3:0]);
    endproperty
    a_base: assert property (p_base)
        else $error("base type class wrong");
    property p_info;
        pkt_valid && hb0 inside {[8'h81:8'h85]} |->
            pkt_out.pkt_class == dipf_pkg::DIPF_CLS_INFO_FRAME;
    endproperty
    a_info: assert property (p_info)
        else $error("info frame class wrong");
    property p_null;
        pkt_valid && hb0 == 8'h00 |-> pkt_out.header_byte_one == 8'h00 &&
            pkt_out.header_byte_two == 8'h00 &&
            pkt_out.packet_body_bytes == 224'h0;
    endproperty
    a_null: assert property (p_null)
        else $error("null packet bytes not cleared");
    property p_guard_drop;
        guard_err |-> ##[0:3] !island_active;
    endproperty
    a_guard_drop: assert property (p_guard_drop)
        else $error("island kept after guard error");
    property p_guard_pulse;
        guard_err |=> !guard_err [*4];
    endproperty
    a_guard_pulse: assert property (p_guard_pulse)
        else $error("guard error too long");
    property p_many;
        too_many_pkts |-> island_active;
    endproperty
    a_many: assert property (p_many)
        else $error("packet count flag outside island");
    property p_ovf;
        overflow |-> pkt_valid;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow with empty buffer");
endmodule

bind dipf_deframer dipf_deframer_assertions i_chk (
    .ref_clk, .rst_n, .link_clk, .link_in, .pkt_valid, .pkt_ready,
    .pkt_out, .island_active, .island_sync, .guard_err, .too_many_pkts,
    .short_ctl, .overflow
);

// [verif/dipf_src_model.sv]
`timescale 1ns/1ns
module dipf_src_model (
    // Link
    output logic link_clk,
    output dipf_pkg::dipf_link_t link_in
);
    initial begin
        link_clk = 1'b0;
        link_in = '{1'b1, 4'h0, 4'h0, 4'h0, 4'h0, 10'h2CC, 10'h2CC};
        #7;
        forever #16 link_clk = ~link_clk;
    end

    function automatic logic [7:0] bch(input logic [55:0] d, input int n);
        logic [7:0] e;
        logic fb;
        e = 8'h00;
        for (int i = 0; i < n; i++) begin
            fb = d[i] ^ e[0];
            e = (e >> 1) ^ (fb ? 8'h83 : 8'h00);
        end
        return e;
    endfunction

    task automatic put(input logic c, input logic [3:0] k, n0, n1, n2,
        input logic [9:0] ch);
        @(posedge link_clk);
        link_in <= '{c, k, n0, n1, n2, ch, ch};
    endtask

    // One island of np packets; err flips parity bits, bad spoils guard
    task automatic island(input int np, idle, input logic [23:0] hdr,
        input logic [223:0] body, input logic [1:0] sy,
        input logic [4:0] err, input logic bad);
        logic [31:0] hb;
        logic [63:0] blk [4];
        logic [3:0] n1, n2;
        hb = {bch({32'h0, hdr}, 24) ^ {7'h0, err[0]}, hdr};
        for (int k = 0; k < 4; k++)
            blk[k] = {bch(body[56*k +: 56], 56) ^ {7'h0, err[k+1]},
                body[56*k +: 56]};
        repeat (idle) put(1'b1, 4'h0, {2'h0, sy}, 4'h0, 4'h0, 10'h2CC);
        repeat (8) put(1'b1, 4'h5, {2'h0, sy}, 4'h0, 4'h0, 10'h2CC);
        put(1'b0, 4'h0, {2'h3, sy}, 4'h0, 4'h0, 10'h133);
        put(1'b0, 4'h0, {2'h3, sy}, 4'h0, 4'h0, bad ? 10'h2CC : 10'h133);
        repeat (np) begin
            for (int t = 0; t < 32; t++) begin
                for (int k = 0; k < 4; k++) begin
                    n1[k] = blk[k][2*t];
                    n2[k] = blk[k][2*t+1];
                end
                put(1'b0, 4'h0, {1'b0, hb[t], sy}, n1, n2, 10'h2CC);
            end
        end
        repeat (2) put(1'b0, 4'h0, {2'h3, sy}, 4'h0, 4'h0, 10'h133);
        put(1'b1, 4'h0, {2'h0, sy}, 4'h0, 4'h0, 10'h2CC);
    endtask
endmodule

// [verif/dipf_deframer_test.sv]
`timescale 1ns/1ns
module dipf_deframer_test;
    logic ref_clk, rst_n, link_clk, pkt_valid, pkt_ready, island_active;
    logic guard_err, too_many_pkts, short_ctl, overflow;
    logic [1:0] island_sync;
    logic [223:0] body;
    dipf_pkg::dipf_link_t link_in;
    dipf_pkg::dipf_packet_t pkt_out, p;
    int fails = 0;
    int cmp_count = 0;
    int n_grd = 0;
    int n_short = 0;
    int n_many = 0;
    int n_ovf = 0;

    dipf_deframer i_dut (.ref_clk, .rst_n, .link_clk, .link_in, .pkt_valid,
        .pkt_ready, .pkt_out, .island_active, .island_sync, .guard_err,
        .too_many_pkts, .short_ctl, .overflow);
    dipf_src_model i_src (.link_clk, .link_in);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        n_grd <= n_grd + 32'(guard_err === 1'b1);
        n_short <= n_short + 32'(short_ctl === 1'b1);
        n_many <= n_many + 32'(too_many_pkts === 1'b1);
        n_ovf <= n_ovf + 32'(overflow === 1'b1);
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pkt(input dipf_pkg::dipf_packet_t got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic get_pkt;
        for (int n = 0; pkt_valid !== 1'b1; n++) begin
            if (n > 3000) begin
                fails++;
                summarize();
            end
            tick(1);
        end
        p = pkt_out;
        pkt_ready = 1'b1;
        tick(1);
        pkt_ready = 1'b0;
        tick(1);
    endtask

    function automatic dipf_pkg::dipf_packet_t exp_pkt(input logic [23:0] h,
        input logic [1:0] sy, input logic [4:0] err);
        dipf_pkg::dipf_packet_t e;
        logic z;
        z = h[7:0] == 8'h00;
        e.pkt_class = h[7:0] <= 8'h0A ? dipf_pkg::dipf_class_t'(h[3:0]) :
            h[7:0] inside {[8'h81:8'h85]} ? dipf_pkg::DIPF_CLS_INFO_FRAME :
            dipf_pkg::DIPF_CLS_UNKNOWN;
        e.header_byte_zero = h[7:0];
        e.header_byte_one = z ? 8'h00 : h[15:8];
        e.header_byte_two = z ? 8'h00 : h[23:16];
        e.packet_body_bytes = z ? 224'h0 : body;
        e.hdr_err = err[0];
        e.sub_err = err[4:1];
        e.sync = sy;
        return e;
    endfunction

    task automatic one(input logic [23:0] h, input logic [1:0] sy,
        input logic [4:0] err);
        i_src.island(1, 3, h, body, sy, err, 1'b0);
        get_pkt();
        chk_pkt(p, exp_pkt(h, sy, err));
    endtask

    task automatic t_types;
        for (int i = 0; i < 18; i++) begin
            for (int b = 0; b < 28; b++) body[8*b +: 8] = 8'(b * 9 + i);
            one({8'(i * 5 + 1), 8'hC3, 8'(i < 11 ? i : i + 8'h75)}, 2'(i),
                5'h00);
        end
        body = 224'h0;
        one(24'h000000, 2'h2, 5'h00);
    endtask

    task automatic t_ecc;
        body = {28{8'h5A}};
        for (int k = 0; k < 5; k++)
            one(24'h123402, 2'h1, 5'(1 << k));
    endtask

    task automatic t_guard;
        int g;
        g = n_grd;
        i_src.island(1, 3, 24'h000002, body, 2'h2, 5'h00, 1'b1);
        tick(20);
        chk_val(n_grd - g, 1);
        chk_val(32'(pkt_valid), 0);
        chk_val(32'(island_active), 0);
    endtask

    task automatic t_short;
        int s;
        s = n_short;
        i_src.island(1, 3, 24'h000003, body, 2'h0, 5'h00, 1'b0);
        i_src.island(1, 0, 24'h000003, body, 2'h0, 5'h00, 1'b0);
        tick(20);
        chk_val(n_short - s, 1);
        while (pkt_valid === 1'b1) get_pkt();
    endtask

    task automatic t_full;
        int o, m;
        o = n_ovf;
        m = n_many;
        i_src.island(19, 3, 24'h000002, body, 2'h3, 5'h00, 1'b0);
        tick(20);
        chk_val(n_ovf - o, 11);
        chk_val(n_many - m, 1);
        repeat (8) begin
            get_pkt();
            chk_pkt(p, exp_pkt(24'h000002, 2'h3, 5'h00));
        end
        tick(2);
        chk_val(32'(pkt_valid), 0);
        chk_val(32'(island_sync), 32'h3);
    endtask

    initial begin
        rst_n = 1'b0;
        pkt_ready = 1'b0;
        body = 224'h0;
        tick(8);
        chk_val(32'({pkt_valid, island_active, island_sync, guard_err,
            too_many_pkts, short_ctl, overflow}), 0);
        rst_n = 1'b1;
        tick(4);
        t_types();
        t_ecc();
        t_guard();
        t_short();
        t_full();
        summarize();
    end
endmodule
